/* logic/art_pkg.sv */
// Purpose: constants and types shared by the auto-reload timer
// Assumes: 8-bit special function register bus, 50 MHz system clock
// Notes: control register layout matches its bit order, msb first
package art_pkg;

    // special function register addresses
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'hC8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;

    // control register bit positions
    localparam int BIT_HIGH_FLAG = 7;
    localparam int BIT_LOW_FLAG = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_CAPTURE_EN = 4;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_UNUSED = 1;
    localparam int BIT_EXT_SEL = 0;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // clock dividers
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;
    localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
    localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

    // byte limits
    localparam logic [7:0] BYTE_MAX = 8'hFF;

    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_byte_irq_enable;
        logic capture_enable;
        logic split_mode_select;
        logic run_control;
        logic unused;
        logic external_clock_select;
    } art_ctrl_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic bit_wr;
        logic [2:0] bit_sel;
        logic bit_val;
    } art_sfr_req_s;

endpackage : art_pkg

/* logic/art_timer.sv */
// Purpose: 16-bit auto-reload timer with split mode and oscillator capture
// Assumes: one system clock; external and low-frequency clocks are async pins
// Notes: byte clock selects and timer irq enable arrive from other registers
module art_timer (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // special function register bus
    input wire art_pkg::art_sfr_req_s sfr_req_in,
    output logic [7:0] sfr_rdata_out,
    // settings held in other registers
    input wire logic high_byte_clock_select_in,
    input wire logic low_byte_clock_select_in,
    input wire logic timer_irq_enable_in,
    // asynchronous clock pins
    input wire logic ext_osc_in,
    input wire logic low_freq_oscillator_in,
    // interrupt request
    output logic irq_out
);

    art_pkg::art_ctrl_s ctrl_r;
    logic [7:0] count_low_byte_r;
    logic [7:0] count_high_byte_r;
    logic [7:0] reload_low_byte_r;
    logic [7:0] reload_high_byte_r;
    logic [7:0] rdata_r;
    logic irq_r;
    logic [3:0] sys_div_r;
    logic [3:0] sys_div_nxt;
    logic [2:0] ext_div_r;
    logic [2:0] ext_div_nxt;
    logic [1:0] pin_raw;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic sys_tick;
    logic ext_tick;
    logic low_tick;
    logic high_tick;
    logic low_inc;
    logic high_inc;
    logic low_wrap;
    logic high_wrap;
    logic capture_evt;
    logic wr_ctrl;
    logic bit_ctrl;
    logic wr_count_low;
    logic wr_count_high;
    logic wr_reload_low;
    logic wr_reload_high;
    logic low_at_max;
    logic high_at_max;
    logic set_high_flag;
    logic set_low_flag;
    logic [7:0] rd_value;
    logic high_pending;
    logic low_pending;
    logic irq_nxt;

    // selected count tick for one byte
    function automatic logic pick_tick(input logic sel, input logic ext, input logic s12,
                                       input logic e8);
        if (sel) begin
            pick_tick = 1'b1;
        end else if (ext) begin
            pick_tick = e8;
        end else begin
            pick_tick = s12;
        end
    endfunction

    // byte write strobe aimed at one register address
    function automatic logic write_hit(input art_pkg::art_sfr_req_s req,
                                       input logic [7:0] addr);
        write_hit = req.wr && (req.addr == addr);
    endfunction

    // byte about to wrap on its next count
    function automatic logic at_max(input logic [7:0] value);
        at_max = (value == art_pkg::BYTE_MAX);
    endfunction

    // two-flop synchronisers plus an edge-history flop, one per pin
    assign pin_raw = {low_freq_oscillator_in, ext_osc_in};

    generate
        for (genvar p = 0; p < 2; p++) begin : g_sync
            logic [2:0] stage_r;

            always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    stage_r <= 3'h0;
                end else begin
                    stage_r <= {stage_r[1:0], pin_raw[p]};
                end
            end

            // only the second and third flops feed the edge detectors
            assign pin_rise[p] = stage_r[1] && !stage_r[2];
            assign pin_fall[p] = !stage_r[1] && stage_r[2];
        end
    endgenerate

    // prescaler next values: divide by 12 free-running, divide by 8 on external pin rising edges
    always_comb begin
        if (sys_div_r == art_pkg::SYS_DIV_LAST) begin
            sys_div_nxt = 4'h0;
        end else begin
            sys_div_nxt = sys_div_r + 4'h1;
        end
        if (pin_rise[0]) begin
            ext_div_nxt = ext_div_r + 3'h1;
        end else begin
            ext_div_nxt = ext_div_r;
        end
    end

    // system clock prescaler
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sys_div_r <= 4'h0;
        end else begin
            sys_div_r <= sys_div_nxt;
        end
    end

    // external clock prescaler on synchronised rising edges
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ext_div_r <= 3'h0;
        end else begin
            ext_div_r <= ext_div_nxt;
        end
    end

    // count clock selection per byte
    always_comb begin
        sys_tick = (sys_div_r == art_pkg::SYS_DIV_LAST);
        ext_tick = pin_rise[0] && (ext_div_r == art_pkg::EXT_DIV_LAST);
        low_tick = pick_tick(low_byte_clock_select_in, ctrl_r.external_clock_select,
                             sys_tick, ext_tick);
        high_tick = pick_tick(high_byte_clock_select_in, ctrl_r.external_clock_select,
                              sys_tick, ext_tick);
        capture_evt = ctrl_r.capture_enable && pin_fall[1];
    end

    // mode gating and wrap detection
    always_comb begin
        low_at_max = at_max(count_low_byte_r);
        high_at_max = at_max(count_high_byte_r);
        if (ctrl_r.split_mode_select) begin
            low_inc = low_tick;
            high_inc = high_tick && ctrl_r.run_control;
        end else begin
            low_inc = low_tick && ctrl_r.run_control;
            high_inc = low_inc && low_at_max;
        end
        low_wrap = low_inc && low_at_max;
        high_wrap = high_inc && high_at_max;
    end

    // hardware flag events; these override a software clear in the same cycle
    always_comb begin
        set_high_flag = high_wrap || capture_evt;
        set_low_flag = low_wrap;
    end

    // register bus decode
    always_comb begin
        wr_ctrl = write_hit(sfr_req_in, art_pkg::ADDR_TIMER_CONTROL);
        bit_ctrl = sfr_req_in.bit_wr && (sfr_req_in.addr == art_pkg::ADDR_TIMER_CONTROL);
        wr_count_low = write_hit(sfr_req_in, art_pkg::ADDR_COUNT_LOW);
        wr_count_high = write_hit(sfr_req_in, art_pkg::ADDR_COUNT_HIGH);
        wr_reload_low = write_hit(sfr_req_in, art_pkg::ADDR_RELOAD_LOW);
        wr_reload_high = write_hit(sfr_req_in, art_pkg::ADDR_RELOAD_HIGH);
    end

    // control register: byte and bit writes, flags set by hardware
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_r <= art_pkg::CONTROL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= sfr_req_in.wdata;
            end else if (bit_ctrl) begin
                ctrl_r[sfr_req_in.bit_sel] <= sfr_req_in.bit_val;
            end
            ctrl_r.unused <= 1'b0;
            if (set_high_flag) begin
                ctrl_r.high_overflow_flag <= 1'b1;
            end
            if (set_low_flag) begin
                ctrl_r.low_overflow_flag <= 1'b1;
            end
        end
    end

    // low count byte
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_low_byte_r <= art_pkg::BYTE_RESET;
        end else if (wr_count_low) begin
            count_low_byte_r <= sfr_req_in.wdata;
        end else if (low_wrap) begin
            if (ctrl_r.split_mode_select || high_wrap) begin
                count_low_byte_r <= reload_low_byte_r;
            end else begin
                count_low_byte_r <= 8'h00;
            end
        end else if (low_inc) begin
            count_low_byte_r <= count_low_byte_r + 8'h01;
        end
    end

    // high count byte
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            count_high_byte_r <= art_pkg::BYTE_RESET;
        end else if (wr_count_high) begin
            count_high_byte_r <= sfr_req_in.wdata;
        end else if (high_wrap) begin
            count_high_byte_r <= reload_high_byte_r;
        end else if (high_inc) begin
            count_high_byte_r <= count_high_byte_r + 8'h01;
        end
    end

    // reload low byte, loaded by software or by a capture
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reload_low_byte_r <= art_pkg::BYTE_RESET;
        end else if (capture_evt) begin
            reload_low_byte_r <= count_low_byte_r;
        end else if (wr_reload_low) begin
            reload_low_byte_r <= sfr_req_in.wdata;
        end
    end

    // reload high byte, same priority as the low byte
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reload_high_byte_r <= art_pkg::BYTE_RESET;
        end else if (capture_evt) begin
            reload_high_byte_r <= count_high_byte_r;
        end else if (wr_reload_high) begin
            reload_high_byte_r <= sfr_req_in.wdata;
        end
    end

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        case (sfr_req_in.addr)
            art_pkg::ADDR_TIMER_CONTROL: rd_value = ctrl_r;
            art_pkg::ADDR_RELOAD_LOW: rd_value = reload_low_byte_r;
            art_pkg::ADDR_RELOAD_HIGH: rd_value = reload_high_byte_r;
            art_pkg::ADDR_COUNT_LOW: rd_value = count_low_byte_r;
            art_pkg::ADDR_COUNT_HIGH: rd_value = count_high_byte_r;
            default: rd_value = 8'h00;
        endcase
    end

    // read data, one cycle after the read strobe, zero otherwise
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_r <= 8'h00;
        end else if (sfr_req_in.rd) begin
            rdata_r <= rd_value;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // pending sources: high flag always, low flag only with its enable
    always_comb begin
        high_pending = ctrl_r.high_overflow_flag;
        low_pending = ctrl_r.low_byte_irq_enable && ctrl_r.low_overflow_flag;
        irq_nxt = timer_irq_enable_in && (high_pending || low_pending);
    end

    // interrupt request follows the pending flags gated by timer_irq_enable_in, one cycle later
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign sfr_rdata_out = rdata_r;
    assign irq_out = irq_r;

endmodule // art_timer

/* test/art_timer_assertions.sv */
// Purpose: port checker for art_timer
// Assumes: one clock, async active-high reset
// Notes: bound to every art_timer instance
module art_timer_assertions (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // register bus
    input wire art_pkg::art_sfr_req_s sfr_req_in,
    input wire logic [7:0] sfr_rdata_out,
    // settings and pins
    input wire logic high_byte_clock_select_in,
    input wire logic low_byte_clock_select_in,
    input wire logic timer_irq_enable_in,
    input wire logic ext_osc_in,
    input wire logic low_freq_oscillator_in,
    input wire logic irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic ctl_hit;
    logic ctl_wr;
    logic unmapped;
    assign ctl_hit = sfr_req_in.addr == art_pkg::ADDR_TIMER_CONTROL;
    assign ctl_wr = (sfr_req_in.wr || sfr_req_in.bit_wr) && ctl_hit;
    assign unmapped = !ctl_hit && (sfr_req_in.addr < 8'hCA || sfr_req_in.addr > 8'hCD);
    sequence s_ctl_wr_rd;
        sfr_req_in.wr && ctl_hit ##1 sfr_req_in.rd && ctl_hit;
    endsequence
    sequence s_set_high;
        sfr_req_in.bit_wr && ctl_hit && !sfr_req_in.wr && sfr_req_in.bit_sel == 3'h7
            && sfr_req_in.bit_val ##1 timer_irq_enable_in;
    endsequence
    property p_idle_zero; !sfr_req_in.rd |=> sfr_rdata_out == 8'h00; endproperty
    property p_unused; sfr_req_in.rd && ctl_hit |=> !sfr_rdata_out[1]; endproperty
    property p_readback;
        s_ctl_wr_rd |=> (sfr_rdata_out & 8'h3D) == ($past(sfr_req_in.wdata, 2) & 8'h3D);
    endproperty
    property p_unmapped; sfr_req_in.rd && unmapped |=> sfr_rdata_out == 8'h00; endproperty
    property p_irq_gate; !timer_irq_enable_in |=> !irq_out; endproperty
    property p_irq_rise; $rose(irq_out) |-> $past(timer_irq_enable_in); endproperty
    property p_irq_hold;
        irq_out && timer_irq_enable_in && !ctl_wr && !$past(ctl_wr) |=> irq_out;
    endproperty
    property p_irq_set; s_set_high |=> irq_out; endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data not zero when idle");
    a_unused: assert property (p_unused)
        else $error("unused control bit reads one");
    a_readback: assert property (p_readback)
        else $error("control bits do not read back");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq without enable");
    a_irq_rise: assert property (p_irq_rise)
        else $error("irq rose without enable");
    a_irq_hold: assert property (p_irq_hold)
        else $error("irq dropped without software write");
    a_irq_set: assert property (p_irq_set)
        else $error("high flag set gave no irq");
endmodule // art_timer_assertions

bind art_timer art_timer_assertions art_timer_assertions_i (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .sfr_req_in(sfr_req_in),
    .sfr_rdata_out(sfr_rdata_out), .high_byte_clock_select_in(high_byte_clock_select_in),
    .low_byte_clock_select_in(low_byte_clock_select_in),
    .timer_irq_enable_in(timer_irq_enable_in), .ext_osc_in(ext_osc_in),
    .low_freq_oscillator_in(low_freq_oscillator_in), .irq_out(irq_out));

/* test/testbench.sv */
// Purpose: self-checking bench for art_timer
// Assumes: 50 MHz clock, bench drives every input port
// Notes: each scenario judges its own results
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CTL = art_pkg::ADDR_TIMER_CONTROL;
    localparam logic [7:0] RLL = art_pkg::ADDR_RELOAD_LOW;
    localparam logic [7:0] RLH = art_pkg::ADDR_RELOAD_HIGH;
    localparam logic [7:0] CNL = art_pkg::ADDR_COUNT_LOW;
    localparam logic [7:0] CNH = art_pkg::ADDR_COUNT_HIGH;
    logic clk = 1'b0;
    logic rst = 1'b1;
    art_pkg::art_sfr_req_s sreq = '0;
    logic hsel = 1'b0, lsel = 1'b0, ien = 1'b0, ext = 1'b0, low_freq_oscillator = 1'b0;
    logic [7:0] rdata;
    logic irq;
    int err_total = 0;
    int num_checks = 0;
    always #10 clk = ~clk;
    art_timer art_timer_i (.sys_clk_in(clk), .sys_rst_in(rst), .sfr_req_in(sreq),
        .sfr_rdata_out(rdata), .high_byte_clock_select_in(hsel),
        .low_byte_clock_select_in(lsel), .timer_irq_enable_in(ien),
        .ext_osc_in(ext), .low_freq_oscillator_in(low_freq_oscillator), .irq_out(irq));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic put(input art_pkg::art_sfr_req_s r);
        @(posedge clk) sreq <= r;
        @(posedge clk) sreq <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        put('{a, d, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0});
    endtask
    task automatic bw(input logic [2:0] s, input logic v);
        put('{CTL, 8'h00, 1'b0, 1'b0, 1'b1, s, v});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        put('{a, 8'h00, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0});
        #1 chk8(rdata & m, e);
    endtask
    task automatic wr_rd(input logic [7:0] d, input logic [7:0] e);
        @(posedge clk) sreq <= '{CTL, d, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0};
        @(posedge clk) sreq <= '{CTL, 8'h00, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0};
        @(posedge clk) sreq <= '0;
        #1 chk8(rdata, e);
    endtask
    task automatic t_reset();
        rd(CTL, 8'hFF, art_pkg::CONTROL_RESET);
        rd(RLH, 8'hFF, art_pkg::BYTE_RESET);
        wr(8'hC9, 8'h5A);
        rd(8'hC9, 8'hFF, 8'h00);
    endtask
    task automatic t_ctrl();
        wr_rd(8'hFF, 8'hFD);
        repeat (20) @(posedge clk);
        rd(CTL, 8'hFF, 8'hFD);
        wr_rd(8'h00, 8'h00);
        @(posedge clk) ien <= 1'b1;
        bw(3'h7, 1'b1);
        rd(CTL, 8'hFF, 8'h80);
        chk1(irq, 1'b1);
        bw(3'h7, 1'b0);
        bw(3'h6, 1'b1);
        rd(CTL, 8'hFF, 8'h40);
        chk1(irq, 1'b0);
        bw(3'h5, 1'b1);
        rd(CTL, 8'hFF, 8'h60);
        chk1(irq, 1'b1);
        wr(CTL, 8'h00);
    endtask
    task automatic t_wide();
        wr(RLH, 8'h12);
        wr(RLL, 8'h34);
        wr(CNH, 8'hFF);
        wr(CNL, 8'hFE);
        @(posedge clk) lsel <= 1'b1;
        bw(3'h2, 1'b1);
        repeat (4) @(posedge clk);
        bw(3'h2, 1'b0);
        rd(CTL, 8'hFF, 8'hC0);
        rd(CNH, 8'hFF, 8'h12);
        rd(CNL, 8'hF0, 8'h30);
        chk1(irq, 1'b1);
        wr(CTL, 8'h00);
        rd(CTL, 8'hFF, 8'h00);
        chk1(irq, 1'b0);
        wr(CNH, 8'hFF);
        wr(CNL, 8'hFE);
        wr(CTL, 8'h04);
        bw(3'h7, 1'b0);
        rd(CTL, 8'hC0, 8'hC0);
        wr(CTL, 8'h00);
    endtask
    task automatic t_split();
        @(posedge clk) lsel <= 1'b0;
        wr(RLL, 8'h80);
        wr(RLH, 8'h55);
        wr(CNL, 8'hFF);
        wr(CNH, 8'hFF);
        wr(CTL, 8'h08);
        repeat (30) @(posedge clk);
        rd(CNH, 8'hFF, 8'hFF);
        rd(CNL, 8'hF0, 8'h80);
        rd(CTL, 8'hFF, 8'h48);
        @(posedge clk) hsel <= 1'b1;
        bw(3'h2, 1'b1);
        repeat (4) @(posedge clk);
        bw(3'h2, 1'b0);
        rd(CNH, 8'hF0, 8'h50);
        rd(CTL, 8'hFF, 8'hC8);
        wr(CTL, 8'h00);
    endtask
    task automatic t_ext();
        wr(CNH, 8'h00);
        wr(CNL, 8'h00);
        wr(CTL, 8'h05);
        repeat (16) begin
            repeat (3) @(posedge clk);
            ext <= 1'b1;
            repeat (3) @(posedge clk);
            ext <= 1'b0;
        end
        repeat (6) @(posedge clk);
        rd(CNL, 8'hFF, 8'h02);
        wr(CTL, 8'h00);
    endtask
    task automatic t_cap();
        @(posedge clk) hsel <= 1'b0;
        lsel <= 1'b1;
        wr(RLH, 8'hAA);
        wr(CNH, 8'h00);
        wr(CNL, 8'h00);
        wr(CTL, 8'h14);
        @(posedge clk) low_freq_oscillator <= 1'b1;
        repeat (20) @(posedge clk);
        low_freq_oscillator <= 1'b0;
        repeat (8) @(posedge clk);
        rd(CTL, 8'hFF, 8'h94);
        rd(RLH, 8'hFF, 8'h00);
        rd(RLL, 8'hF0, 8'h10);
        chk1(irq, 1'b1);
        wr(CTL, 8'h00);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ctrl();
        t_wide();
        t_split();
        t_ext();
        t_cap();
        wrap_up();
    end
endmodule // testbench
